// ### rtl/rcr_pkg.sv
// package of constants and types for the reset cause recorder
//
// Contract
// - Every true reset (power-on, brown-out, master clear, watchdog reset, reset opcode, stack fault) loads the program counter with 0000h.
// - An interrupt wake from sleep continues at PC + 1, sets the timeout flag, clears the power-down flag and leaves the power control flags alone.
// - An interrupt wake with the global interrupt enable set runs the next instruction first, then pushes the return address and jumps to 0004h.
// - A watchdog wake from sleep continues at PC + 1, clears the timeout and power-down flags and leaves the power control flags alone.
// - A master clear pin reset while awake clears only the master clear flag.
// - A master clear pin reset during sleep sets the timeout flag, clears the power-down flag and clears the master clear flag.
// - A stack overflow with stack fault reset enabled resets and sets only the stack overflow flag.
// - A stack underflow with stack fault reset enabled resets and sets only the stack underflow flag.
// - Unimplemented flag positions read as zero.
// - Power-on reset sets timeout and power-down, clears both stack flags and the power-on flag, sets master clear and reset opcode flags.

`default_nettype none

package rcr_pkg;

  // ----------------------------------------------------------------
  // program counter values
  // ----------------------------------------------------------------
  localparam int PC_WIDTH_DEF = 13;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] IRQ_VECTOR = 16'h0004;

  // ----------------------------------------------------------------
  // power control register bit positions
  // ----------------------------------------------------------------
  localparam int PCR_WIDTH = 8;
  localparam int BIT_STACK_OVF = 7;
  localparam int BIT_STACK_UNF = 6;
  localparam int BIT_MASTER_CLR = 3;
  localparam int BIT_ROPC = 2;
  localparam int BIT_POR = 1;
  localparam int BIT_BROWNOUT = 0;
  // implemented positions; all others read as zero
  localparam logic [7:0] PCR_IMPL_MASK = 8'hCF;
  // value held after the asynchronous reset (power-on image)
  localparam logic [7:0] PCR_RESET = 8'h0C;
  localparam logic TIMEOUT_RESET = 1'b1;
  localparam logic POWERDOWN_RESET = 1'b1;

  // ----------------------------------------------------------------
  // cause of the current event, highest priority first
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    RCR_NONE = 4'h0,
    RCR_POR = 4'h1,
    RCR_BROWNOUT = 4'h2,
    RCR_MASTER_CLR = 4'h3,
    RCR_WATCHDOG = 4'h4,
    RCR_ROPC = 4'h5,
    RCR_STACK_OVF = 4'h6,
    RCR_STACK_UNF = 4'h7,
    RCR_IRQWAKE = 4'h8
  } rcr_cause_t;

endpackage : rcr_pkg

`default_nettype wire

// ### rtl/rcr_cause_sel.sv
// priority selection of the reset or wake cause
`timescale 1ns/10ps
`default_nettype none

module rcr_cause_sel (
  input wire logic porEvt,
  input wire logic brownoutEvt,
  input wire logic masterClrEvt,
  input wire logic watchdogEvt,
  input wire logic resetOpEvt,
  input wire logic stkOvfEvt,
  input wire logic stkUnfEvt,
  input wire logic irqWakeEvt,
  input wire logic asleep,
  input wire logic stack_fault_reset_enable,
  output var rcr_pkg::rcr_cause_t cause
);
  import rcr_pkg::*;

  // ----------------------------------------------------------------
  // qualified requests
  // ----------------------------------------------------------------
  // stack faults only reset when enabled; otherwise the core keeps running
  wire logic ovfReq = stkOvfEvt & stack_fault_reset_enable;
  wire logic unfReq = stkUnfEvt & stack_fault_reset_enable;
  // an interrupt can only wake a sleeping core
  wire logic irqReq = irqWakeEvt & asleep;

  // supply events outrank pin and core events, the interrupt wake ranks last
  assign cause = porEvt ? RCR_POR :
                 brownoutEvt ? RCR_BROWNOUT :
                 masterClrEvt ? RCR_MASTER_CLR :
                 watchdogEvt ? RCR_WATCHDOG :
                 resetOpEvt ? RCR_ROPC :
                 ovfReq ? RCR_STACK_OVF :
                 unfReq ? RCR_STACK_UNF :
                 irqReq ? RCR_IRQWAKE : RCR_NONE;

endmodule : rcr_cause_sel
`default_nettype wire

// ### rtl/reset_cause_recorder.sv
// reset and wake cause recorder: flags, program counter start point
`timescale 1ns/10ps
`default_nettype none

module reset_cause_recorder #(
  parameter int PC_WIDTH = rcr_pkg::PC_WIDTH_DEF
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic porEvt,
  input wire logic brownoutEvt,
  input wire logic master_clear_pin_evt,
  input wire logic watchdog_evt,
  input wire logic resetOpEvt,
  input wire logic stkOvfEvt,
  input wire logic stkUnfEvt,
  input wire logic irqWakeEvt,
  input wire logic asleep,
  input wire logic stack_fault_reset_enable,
  input wire logic global_irq_enable,
  input wire logic instrDone,
  input wire logic [PC_WIDTH-1:0] pcIn,
  input wire logic swPcrWr,
  input wire logic [rcr_pkg::PCR_WIDTH-1:0] swPcrData,
  output logic coreReset_r,
  output logic pcLoad_r,
  output logic [PC_WIDTH-1:0] pcValue_r,
  output logic pushReturn_r,
  output logic [PC_WIDTH-1:0] returnAddr_r,
  output logic timeout_flag_r,
  output logic powerdown_flag_r,
  output logic [rcr_pkg::PCR_WIDTH-1:0] power_control_reg_r
);
  import rcr_pkg::*;

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // the interrupt vector needs at least three address bits
  if (PC_WIDTH < 3 || PC_WIDTH > 16) begin : gBadWidth
    $error("PC_WIDTH must lie between 3 and 16");
  end

  // ----------------------------------------------------------------
  // cause selection
  // ----------------------------------------------------------------
  rcr_cause_t cause;

  rcr_cause_sel rcr_cause_sel_inst (
    .porEvt(porEvt),
    .brownoutEvt(brownoutEvt),
    .masterClrEvt(master_clear_pin_evt),
    .watchdogEvt(watchdog_evt),
    .resetOpEvt(resetOpEvt),
    .stkOvfEvt(stkOvfEvt),
    .stkUnfEvt(stkUnfEvt),
    .irqWakeEvt(irqWakeEvt),
    .asleep(asleep),
    .stack_fault_reset_enable(stack_fault_reset_enable),
    .cause(cause)
  );

  // ----------------------------------------------------------------
  // decode of the cause
  // ----------------------------------------------------------------
  // a watchdog timeout in sleep is a wake, awake it is a reset
  wire logic watchdogWake = (cause == RCR_WATCHDOG) & asleep;
  wire logic irqWake = (cause == RCR_IRQWAKE);
  wire logic isWake = watchdogWake | irqWake;
  wire logic isReset = (cause != RCR_NONE) & ~isWake;
  wire logic [PC_WIDTH-1:0] pcNext = pcIn + PC_WIDTH'(1);
  wire logic [PC_WIDTH-1:0] rstVec = RESET_VECTOR[PC_WIDTH-1:0];
  wire logic [PC_WIDTH-1:0] irqVec = IRQ_VECTOR[PC_WIDTH-1:0];

  // ----------------------------------------------------------------
  // next flag values
  // ----------------------------------------------------------------
  logic timeout_flag_nxt;
  logic powerdown_flag_nxt;
  logic [PCR_WIDTH-1:0] pcrHw;
  logic [PCR_WIDTH-1:0] pcrBase;

  // software writes land first; a same-cycle hardware event overrides
  // them, so no cause is ever lost to a software clear
  assign pcrBase = swPcrWr ? swPcrData : power_control_reg_r;

  always_comb begin
    timeout_flag_nxt = timeout_flag_r;
    powerdown_flag_nxt = powerdown_flag_r;
    pcrHw = pcrBase;
    case (cause)
      RCR_POR: begin
        timeout_flag_nxt = 1'b1;
        powerdown_flag_nxt = 1'b1;
        pcrHw[BIT_STACK_OVF] = 1'b0;
        pcrHw[BIT_STACK_UNF] = 1'b0;
        pcrHw[BIT_MASTER_CLR] = 1'b1;
        pcrHw[BIT_ROPC] = 1'b1;
        pcrHw[BIT_POR] = 1'b0;
      end
      RCR_BROWNOUT: begin
        timeout_flag_nxt = 1'b1;
        powerdown_flag_nxt = 1'b1;
        pcrHw[BIT_STACK_OVF] = 1'b0;
        pcrHw[BIT_STACK_UNF] = 1'b0;
        pcrHw[BIT_MASTER_CLR] = 1'b1;
        pcrHw[BIT_ROPC] = 1'b1;
        pcrHw[BIT_BROWNOUT] = 1'b0;
      end
      RCR_MASTER_CLR: begin
        pcrHw[BIT_MASTER_CLR] = 1'b0;
        if (asleep) begin
          timeout_flag_nxt = 1'b1;
          powerdown_flag_nxt = 1'b0;
        end
      end
      RCR_WATCHDOG: begin
        timeout_flag_nxt = 1'b0;
        if (asleep) begin
          powerdown_flag_nxt = 1'b0;
        end
      end
      RCR_ROPC: pcrHw[BIT_ROPC] = 1'b0;
      RCR_STACK_OVF: pcrHw[BIT_STACK_OVF] = 1'b1;
      RCR_STACK_UNF: pcrHw[BIT_STACK_UNF] = 1'b1;
      RCR_IRQWAKE: begin
        timeout_flag_nxt = 1'b1;
        powerdown_flag_nxt = 1'b0;
      end
      default: begin
        timeout_flag_nxt = timeout_flag_r;
        powerdown_flag_nxt = powerdown_flag_r;
      end
    endcase
  end

  // unimplemented positions never hold a one
  wire logic [PCR_WIDTH-1:0] pcr_nxt = pcrHw & PCR_IMPL_MASK;

  // ----------------------------------------------------------------
  // program counter steering
  // ----------------------------------------------------------------
  logic vecPending_r;
  // the vector is taken once the instruction after the sleep retires
  // a wake in the same cycle owns the pc load, so the take waits for it
  wire logic vecTake = vecPending_r & instrDone & ~isReset & ~isWake;
  wire logic vecPending_nxt = isReset ? 1'b0 :
                              irqWake ? global_irq_enable :
                              vecTake ? 1'b0 : vecPending_r;
  wire logic pcLoad_nxt = isReset | isWake | vecTake;
  wire logic [PC_WIDTH-1:0] pcValue_nxt =
    isReset ? rstVec :
    isWake ? pcNext :
    vecTake ? irqVec : pcValue_r;

  // ----------------------------------------------------------------
  // flag registers
  // ----------------------------------------------------------------
  // reset image is the power-on state; the brown-out flag starts at zero
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      timeout_flag_r <= TIMEOUT_RESET;
      powerdown_flag_r <= POWERDOWN_RESET;
      power_control_reg_r <= PCR_RESET;
    end else begin
      timeout_flag_r <= timeout_flag_nxt;
      powerdown_flag_r <= powerdown_flag_nxt;
      power_control_reg_r <= pcr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // program counter and core control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      coreReset_r <= 1'b1;
      pcLoad_r <= 1'b0;
      pcValue_r <= '0;
      pushReturn_r <= 1'b0;
      returnAddr_r <= '0;
      vecPending_r <= 1'b0;
    end else begin
      coreReset_r <= isReset;
      pcLoad_r <= pcLoad_nxt;
      pcValue_r <= pcValue_nxt;
      pushReturn_r <= vecTake;
      returnAddr_r <= vecTake ? pcIn : returnAddr_r;
      vecPending_r <= vecPending_nxt;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  reset_vector_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    isReset |=> pcLoad_r && coreReset_r && pcValue_r == rstVec)
    else $error("reset did not load the reset vector");

  irq_wake_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    irqWake |=> timeout_flag_r && !powerdown_flag_r && pcLoad_r
      && pcValue_r == $past(pcIn) + PC_WIDTH'(1)
      && power_control_reg_r == $past(pcr_nxt))
    else $error("interrupt wake flags or pc wrong");

  irq_vector_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    vecTake |=> pushReturn_r && pcLoad_r && pcValue_r == irqVec
      && returnAddr_r == $past(pcIn))
    else $error("vector jump after wake missing");

  no_early_vec_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    irqWake && global_irq_enable ##1 !instrDone |=> !pushReturn_r)
    else $error("vector taken before next instruction");

  watchdog_wake_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    watchdogWake && !swPcrWr |=> !timeout_flag_r && !powerdown_flag_r
      && !coreReset_r && $stable(power_control_reg_r))
    else $error("watchdog wake flags wrong");

  master_clr_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    cause == RCR_MASTER_CLR && !asleep |=>
      !power_control_reg_r[BIT_MASTER_CLR]
      && $stable(timeout_flag_r) && $stable(powerdown_flag_r))
    else $error("master clear awake flags wrong");

  master_clr_sleep_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    cause == RCR_MASTER_CLR && asleep |=> timeout_flag_r
      && !powerdown_flag_r && !power_control_reg_r[BIT_MASTER_CLR])
    else $error("master clear in sleep flags wrong");

  stack_ovf_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    cause == RCR_STACK_OVF |=> power_control_reg_r[BIT_STACK_OVF]
      && coreReset_r)
    else $error("stack overflow not recorded");

  stack_unf_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    cause == RCR_STACK_UNF |=> power_control_reg_r[BIT_STACK_UNF]
      && coreReset_r)
    else $error("stack underflow not recorded");

  unimpl_zero_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (power_control_reg_r & ~PCR_IMPL_MASK) == '0)
    else $error("unimplemented bit reads one");

  por_image_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    cause == RCR_POR |=> timeout_flag_r && powerdown_flag_r
      && !power_control_reg_r[BIT_STACK_OVF]
      && !power_control_reg_r[BIT_STACK_UNF]
      && power_control_reg_r[BIT_MASTER_CLR]
      && power_control_reg_r[BIT_ROPC] && !power_control_reg_r[BIT_POR])
    else $error("power-on flag image wrong");

  brownout_image_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    cause == RCR_BROWNOUT |=> timeout_flag_r && powerdown_flag_r
      && !power_control_reg_r[BIT_BROWNOUT]
      && power_control_reg_r[BIT_MASTER_CLR]
      && power_control_reg_r[BIT_POR] == $past(pcrBase[BIT_POR]))
    else $error("brown-out flag image wrong");

  watchdog_reset_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    cause == RCR_WATCHDOG && !asleep |=> !timeout_flag_r
      && $stable(powerdown_flag_r))
    else $error("watchdog reset flags wrong");

endmodule : reset_cause_recorder
`default_nettype wire

// ### bench/reset_cause_recorder_tb.sv
// self-checking testbench for the reset cause recorder
`timescale 1ns/10ps
`default_nettype none

module reset_cause_recorder_tb;
  import rcr_pkg::*;
  localparam int PW = 13;
  // event vector bits: irq, unf, ovf, rop, watchdog, pin, brown-out, por
  localparam logic [7:0] E_POR = 8'h01;
  localparam logic [7:0] E_BROWN = 8'h02;
  localparam logic [7:0] E_MASTER = 8'h04;
  localparam logic [7:0] E_WATCH = 8'h08;
  localparam logic [7:0] E_ROP = 8'h10;
  localparam logic [7:0] E_OVF = 8'h20;
  localparam logic [7:0] E_UNF = 8'h40;
  localparam logic [7:0] E_IRQ = 8'h80;

  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk_sys, rstn, asleep, stkEn, irqEn, instrDone, swPcrWr;
  logic [7:0] evt, swPcrData;
  logic [PW-1:0] pcIn, pcValue_r, returnAddr_r;
  logic coreReset_r, pcLoad_r, pushReturn_r;
  logic timeout_flag_r, powerdown_flag_r;
  logic [7:0] power_control_reg_r;
  int failures = 0;
  int total_checks = 0;

  reset_cause_recorder #(.PC_WIDTH(PW)) reset_cause_recorder_inst (
    .clk_sys(clk_sys), .rstn(rstn), .porEvt(evt[0]),
    .brownoutEvt(evt[1]),
    .master_clear_pin_evt(evt[2]), .watchdog_evt(evt[3]),
    .resetOpEvt(evt[4]), .stkOvfEvt(evt[5]), .stkUnfEvt(evt[6]),
    .irqWakeEvt(evt[7]), .asleep(asleep),
    .stack_fault_reset_enable(stkEn), .global_irq_enable(irqEn),
    .instrDone(instrDone), .pcIn(pcIn), .swPcrWr(swPcrWr),
    .swPcrData(swPcrData), .coreReset_r(coreReset_r),
    .pcLoad_r(pcLoad_r), .pcValue_r(pcValue_r),
    .pushReturn_r(pushReturn_r), .returnAddr_r(returnAddr_r),
    .timeout_flag_r(timeout_flag_r), .powerdown_flag_r(powerdown_flag_r),
    .power_control_reg_r(power_control_reg_r)
  );

  // 125 MHz core clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // shared drivers and comparisons
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one-cycle event pulse; outputs are judged at the following negedge
  task automatic fire(input logic [7:0] e);
    @(negedge clk_sys);
    evt = e;
    @(negedge clk_sys);
    evt = 8'h00;
  endtask : fire

  task automatic wr(input logic [7:0] d);
    @(negedge clk_sys);
    swPcrWr = 1'b1;
    swPcrData = d;
    @(negedge clk_sys);
    swPcrWr = 1'b0;
  endtask : wr

  // pc value is only judged when a load is expected, it holds otherwise
  task automatic expect_out(input string nm, input int rst,
                            input int ld, input logic [15:0] pcv,
                            input int to, input int dn,
                            input logic [7:0] pc);
    chk({nm, " reset"}, 16'(rst), {15'h0000, coreReset_r});
    chk({nm, " load"}, 16'(ld), {15'h0000, pcLoad_r});
    if (ld != 0) chk({nm, " pc"}, pcv, {3'h0, pcValue_r});
    chk({nm, " timeout"}, 16'(to), {15'h0000, timeout_flag_r});
    chk({nm, " powerdown"}, 16'(dn), {15'h0000, powerdown_flag_r});
    chk({nm, " pwr ctl"}, {8'h00, pc}, {8'h00, power_control_reg_r});
  endtask : expect_out

  task automatic final_report();
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic power_case();
    wr(8'hFF);
    chk("pwr ctl write", 16'h00CF, {8'h00, power_control_reg_r});
    fire(E_POR);
    expect_out("por", 1, 1, RESET_VECTOR, 1, 1, 8'h0D);
    wr(8'hC2);
    fire(E_BROWN);
    expect_out("brown", 1, 1, RESET_VECTOR, 1, 1, 8'h0E);
    fire(E_POR | E_MASTER);
    expect_out("por and pin", 1, 1, RESET_VECTOR, 1, 1, 8'h0C);
  endtask : power_case

  task automatic sleep_watchdog_case();
    wr(8'hCF);
    asleep = 1'b1;
    pcIn = 13'h0123;
    fire(E_WATCH);
    asleep = 1'b0;
    expect_out("watchdog wake", 0, 1, 16'h0124, 0, 0, 8'hCF);
    fire(E_MASTER);
    expect_out("pin awake", 1, 1, RESET_VECTOR, 0, 0, 8'hC7);
  endtask : sleep_watchdog_case

  // wake at the top of the counter range, then the deferred vector take
  task automatic irq_wake_case();
    asleep = 1'b1;
    irqEn = 1'b1;
    pcIn = 13'h1FFE;
    fire(E_IRQ);
    asleep = 1'b0;
    expect_out("irq wake", 0, 1, 16'h1FFF, 1, 0, 8'hC7);
    @(negedge clk_sys);
    instrDone = 1'b1;
    pcIn = 13'h0ABC;
    @(negedge clk_sys);
    instrDone = 1'b0;
    chk("push", 16'h0001, {15'h0000, pushReturn_r});
    chk("return addr", 16'h0ABC, {3'h0, returnAddr_r});
    expect_out("vector", 0, 1, IRQ_VECTOR, 1, 0, 8'hC7);
    irqEn = 1'b0;
    asleep = 1'b1;
    fire(E_IRQ);
    asleep = 1'b0;
    expect_out("irq wake off", 0, 1, 16'h0ABD, 1, 0, 8'hC7);
    @(negedge clk_sys);
    instrDone = 1'b1;
    @(negedge clk_sys);
    instrDone = 1'b0;
    chk("no push", 16'h0000, {15'h0000, pushReturn_r});
    fire(E_IRQ);
    expect_out("irq awake", 0, 0, 16'h0000, 1, 0, 8'hC7);
  endtask : irq_wake_case

  task automatic awake_reset_case();
    fire(E_WATCH);
    expect_out("wd reset", 1, 1, RESET_VECTOR, 0, 0, 8'hC7);
    fire(E_ROP);
    expect_out("reset op", 1, 1, RESET_VECTOR, 0, 0, 8'hC3);
  endtask : awake_reset_case

  // stack faults only act while the enable is high
  task automatic stack_case();
    wr(8'h00);
    stkEn = 1'b0;
    fire(E_OVF);
    expect_out("ovf off", 0, 0, 16'h0000, 0, 0, 8'h00);
    stkEn = 1'b1;
    fire(E_OVF);
    expect_out("ovf", 1, 1, RESET_VECTOR, 0, 0, 8'h80);
    fire(E_UNF);
    expect_out("unf", 1, 1, RESET_VECTOR, 0, 0, 8'hC0);
    stkEn = 1'b0;
  endtask : stack_case

  task automatic master_clr_sleep_case();
    wr(8'h08);
    asleep = 1'b1;
    fire(E_MASTER);
    asleep = 1'b0;
    expect_out("pin sleep", 1, 1, RESET_VECTOR, 1, 0, 8'h00);
  endtask : master_clr_sleep_case

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    evt = 8'h00;
    asleep = 1'b0;
    stkEn = 1'b0;
    irqEn = 1'b0;
    instrDone = 1'b0;
    swPcrWr = 1'b0;
    swPcrData = 8'h00;
    pcIn = 13'h0000;
    repeat (20) @(negedge clk_sys);
    expect_out("reset image", 1, 0, 16'h0000, 1, 1, PCR_RESET);
    rstn = 1'b1;
    power_case();
    sleep_watchdog_case();
    irq_wake_case();
    awake_reset_case();
    stack_case();
    master_clr_sleep_case();
    final_report();
  end

  // the whole run needs some 62 cycles; cut a hang well beyond that
  initial begin
    #(8 * 5000);
    failures++;
    final_report();
  end

endmodule : reset_cause_recorder_tb

`default_nettype wire
